// file: rtl/stseq_defines.vh
`ifndef STSEQ_DEFINES_VH
`define STSEQ_DEFINES_VH
// Register offsets
`define STSEQ_REG_CTRL 4'h0
`define STSEQ_REG_COUNT 4'h1
`define STSEQ_REG_DELAY 4'h2
`define STSEQ_REG_SRC 4'h3
`define STSEQ_REG_STAT 4'h4
`define STSEQ_REG_LEN 4'h5
`define STSEQ_REG_CHAN 4'h6
// Control register bits, write-one pulses
`define STSEQ_CTRL_INIT 0
`define STSEQ_CTRL_STEP 1
`define STSEQ_CTRL_ABORT 2
`define STSEQ_CTRL_BUS 3
// Trigger sources
`define STSEQ_SRC_IMM 2'h0
`define STSEQ_SRC_HOLD 2'h1
`define STSEQ_SRC_BUS 2'h2
`define STSEQ_SRC_TTL 2'h3
// Reset values and minimum count
`define STSEQ_COUNT_RST 16'h0001
`define STSEQ_DELAY_RST 16'h0000
`define STSEQ_COUNT_MIN 16'h0001
// Timing
`define STSEQ_CLK_HZ 50000000
`define STSEQ_TICK_US 100
`define STSEQ_TICK_CYC ((`STSEQ_CLK_HZ / 1000000) * `STSEQ_TICK_US)
`endif

// file: rtl/stseq_tick.v
`include "stseq_defines.vh"
module stseq_tick #(
   parameter TICK_CYC = `STSEQ_TICK_CYC
) (
   input wire clk,
   input wire rst,
   input wire run,
   output reg tick
);
   reg [15:0] cnt_r;
   always @(posedge clk) begin
      if (rst || !run) begin
         cnt_r <= 16'h0000;
         tick <= 1'b0;
      end else if (cnt_r == TICK_CYC[15:0] - 16'h0001) begin
         cnt_r <= 16'h0000;
         tick <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 16'h0001;
         tick <= 1'b0;
      end
   end
endmodule

// file: rtl/stseq_sequencer.v
// Our own choices: strobed register access and the register offsets.
`include "stseq_defines.vh"
module stseq_sequencer #(
   parameter TICK_CYC = `STSEQ_TICK_CYC,
   parameter CHW = 8
) (
   input wire clk,
   input wire rst,
   input wire [3:0] regAddr,
   input wire [31:0] regWdata,
   input wire regWr,
   input wire regRd,
   output reg [31:0] regRdata,
   input wire [7:0] ttlTrig,
   output reg [CHW-1:0] relayChan,
   output reg relayClosed,
   output reg busy,
   output reg rangeErr
);
   localparam S_IDLE = 5'b00001;
   localparam S_WAIT = 5'b00010;
   localparam S_DELAY = 5'b00100;
   localparam S_OPEN = 5'b01000;
   localparam S_CLOSE = 5'b10000;

   reg [4:0] state_r;
   reg [15:0] count_r;
   reg [15:0] delay_r;
   reg [1:0] src_r;
   reg [2:0] line_r;
   reg [CHW-1:0] len_r;
   reg [15:0] passLeft_r;
   reg [15:0] delCnt_r;
   reg [7:0] ttlMeta_r;
   reg [7:0] ttlSync_r;
   reg ttlPrev_r;
   reg busTrig_r;
   reg first_r;
   wire tick;

   function wr_hit;
      input [3:0] a;
      begin
         wr_hit = regWr && (regAddr == a);
      end
   endfunction

   wire ctlWr = wr_hit(`STSEQ_REG_CTRL);
   wire initCmd = ctlWr && regWdata[`STSEQ_CTRL_INIT];
   wire stepCmd = ctlWr && regWdata[`STSEQ_CTRL_STEP];
   wire abortCmd = ctlWr && regWdata[`STSEQ_CTRL_ABORT];
   wire busCmd = ctlWr && regWdata[`STSEQ_CTRL_BUS];
   wire ttlNow = ttlSync_r[line_r];
   wire ttlEdge = ttlNow && !ttlPrev_r;
   reg trigEv;
   always @* begin
      trigEv = 1'b0;
      if (src_r == `STSEQ_SRC_TTL) trigEv = ttlEdge;
      else if (src_r == `STSEQ_SRC_BUS) trigEv = busTrig_r;
      else if (src_r == `STSEQ_SRC_IMM) trigEv = 1'b1;
      // Hold source leaves trigEv low
   end

   stseq_tick #(.TICK_CYC(TICK_CYC)) uTick (
      .clk(clk),
      .rst(rst),
      .run(state_r == S_DELAY),
      .tick(tick)
   );

   // Sync of backplane trigger lines
   always @(posedge clk) begin
      if (rst) begin
         ttlMeta_r <= 8'h00;
         ttlSync_r <= 8'h00;
         ttlPrev_r <= 1'b0;
         busTrig_r <= 1'b0;
      end else begin
         ttlMeta_r <= ttlTrig;
         ttlSync_r <= ttlMeta_r;
         ttlPrev_r <= ttlNow;
         busTrig_r <= busCmd;
      end
   end

   // Configuration registers
   always @(posedge clk) begin
      if (rst) begin
         count_r <= `STSEQ_COUNT_RST;
         delay_r <= `STSEQ_DELAY_RST;
         src_r <= `STSEQ_SRC_IMM;
         line_r <= 3'h0;
         len_r <= {{(CHW-1){1'b0}}, 1'b1};
         rangeErr <= 1'b0;
      end else begin
         if (wr_hit(`STSEQ_REG_COUNT)) begin
            if (regWdata[31:16] != 16'h0000 || regWdata[15:0] < `STSEQ_COUNT_MIN)
               rangeErr <= 1'b1;
            else
               count_r <= regWdata[15:0];
         end
         if (wr_hit(`STSEQ_REG_DELAY)) begin
            if (regWdata[31:16] != 16'h0000)
               rangeErr <= 1'b1;
            else
               delay_r <= regWdata[15:0];
         end
         if (wr_hit(`STSEQ_REG_SRC)) begin
            src_r <= regWdata[1:0];
            line_r <= regWdata[4:2];
         end
         if (wr_hit(`STSEQ_REG_LEN) && regWdata[CHW-1:0] != {CHW{1'b0}})
            len_r <= regWdata[CHW-1:0];
         if (wr_hit(`STSEQ_REG_STAT) && regWdata[1])
            rangeErr <= 1'b0;
      end
   end

   // Sequencer
   always @(posedge clk) begin
      if (rst) begin
         state_r <= S_IDLE;
         passLeft_r <= 16'h0000;
         delCnt_r <= 16'h0000;
         relayChan <= {CHW{1'b0}};
         relayClosed <= 1'b0;
         busy <= 1'b0;
         first_r <= 1'b0;
      end else if (abortCmd) begin
         state_r <= S_IDLE;
         relayClosed <= 1'b0;
         busy <= 1'b0;
      end else begin
         case (state_r)
            S_IDLE: begin
               if (initCmd) begin
                  passLeft_r <= count_r;
                  relayChan <= {CHW{1'b0}};
                  relayClosed <= 1'b1;
                  first_r <= 1'b1;
                  busy <= 1'b1;
                  state_r <= S_WAIT;
               end
            end
            S_WAIT: begin
               if (stepCmd) begin
                  state_r <= S_OPEN;
               end else if (trigEv) begin
                  if (delay_r == 16'h0000) begin
                     state_r <= S_OPEN;
                  end else begin
                     delCnt_r <= delay_r;
                     state_r <= S_DELAY;
                  end
               end
            end
            S_DELAY: begin
               if (stepCmd) begin
                  state_r <= S_OPEN;
               end else if (tick) begin
                  delCnt_r <= delCnt_r - 16'h0001;
                  if (delCnt_r == 16'h0001) state_r <= S_OPEN;
               end
            end
            S_OPEN: begin
               relayClosed <= 1'b0;
               first_r <= 1'b0;
               if (relayChan == len_r - {{(CHW-1){1'b0}}, 1'b1}) begin
                  if (passLeft_r == 16'h0001) begin
                     busy <= 1'b0;
                     state_r <= S_IDLE;
                  end else begin
                     passLeft_r <= passLeft_r - 16'h0001;
                     relayChan <= {CHW{1'b0}};
                     state_r <= S_CLOSE;
                  end
               end else begin
                  relayChan <= relayChan + {{(CHW-1){1'b0}}, 1'b1};
                  state_r <= S_CLOSE;
               end
            end
            S_CLOSE: begin
               relayClosed <= 1'b1;
               state_r <= S_WAIT;
            end
            default: state_r <= S_IDLE;
         endcase
      end
   end

   // Read port
   always @(posedge clk) begin
      if (rst) begin
         regRdata <= 32'h00000000;
      end else if (regRd) begin
         if (regAddr == `STSEQ_REG_COUNT) regRdata <= {16'h0000, count_r};
         else if (regAddr == `STSEQ_REG_DELAY) regRdata <= {16'h0000, delay_r};
         else if (regAddr == `STSEQ_REG_SRC) regRdata <= {27'h0000000, line_r, src_r};
         else if (regAddr == `STSEQ_REG_STAT)
            regRdata <= {29'h00000000, relayClosed, rangeErr, busy};
         else if (regAddr == `STSEQ_REG_LEN)
            regRdata <= {{(32-CHW){1'b0}}, len_r};
         else if (regAddr == `STSEQ_REG_CHAN)
            regRdata <= {{(32-CHW){1'b0}}, relayChan};
         else regRdata <= 32'h00000000;
      end else begin
         regRdata <= 32'h00000000;
      end
   end
endmodule

// file: tb/stseq_sequencer_properties.sv
module stseq_sequencer_properties #(parameter CHW = 8) (
   input wire clk,
   input wire rst,
   input wire [3:0] regAddr,
   input wire [31:0] regWdata,
   input wire regWr,
   input wire regRd,
   input wire [31:0] regRdata,
   input wire [7:0] ttlTrig,
   input wire [CHW-1:0] relayChan,
   input wire relayClosed,
   input wire busy,
   input wire rangeErr
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   wire wrCnt = regWr && regAddr == 4'h1;
   wire wrCtl = regWr && regAddr == 4'h0;
   chan_hold_a: assert property ($changed(relayChan) && $past(relayClosed) |-> !relayClosed)
      else $error("channel moved while closed");
   init_run_a: assert property (wrCtl && regWdata[0] && !regWdata[2] && !busy
      |=> busy && relayClosed && relayChan == 0) else $error("init did not start");
   cnt_zero_a: assert property (wrCnt && regWdata == 32'h0 |=> rangeErr)
      else $error("zero count taken");
   cnt_big_a: assert property (wrCnt && regWdata[31:16] != 16'h0 |=> rangeErr)
      else $error("large count taken");
   dly_big_a: assert property (regWr && regAddr == 4'h2 && regWdata[31:16] != 16'h0
      |=> rangeErr) else $error("large delay taken");
   idle_open_a: assert property (!busy |-> !relayClosed)
      else $error("relay closed while idle");
   re_close_a: assert property (busy && $fell(relayClosed) |=> relayClosed)
      else $error("next relay not closed");
   step_now_a: assert property (wrCtl && regWdata[1] && busy && relayClosed
      && $past(relayClosed) && $past(relayClosed, 2) |-> ##[1:2] !relayClosed)
      else $error("step not taken");
endmodule

bind stseq_sequencer stseq_sequencer_properties #(.CHW(CHW)) i_props (.clk, .rst,
   .regAddr, .regWdata, .regWr, .regRd, .regRdata, .ttlTrig, .relayChan,
   .relayClosed, .busy, .rangeErr);

// file: tb/stseq_relay_model.sv
module stseq_relay_model (
   input wire clk,
   input wire [7:0] relayChan,
   input wire relayClosed,
   output int closeCnt,
   output logic overlap
);
   timeunit 1ns;
   timeprecision 1ns;
   logic prevClosed = 1'b0;
   logic [7:0] prevChan = 8'h0;
   initial closeCnt = 0;
   initial overlap = 1'b0;
   always @(posedge clk) begin
      if (relayClosed && !prevClosed) closeCnt <= closeCnt + 1;
      if (relayClosed && prevClosed && relayChan != prevChan) overlap <= 1'b1;
      prevClosed <= relayClosed;
      prevChan <= relayChan;
   end
endmodule

// file: tb/stseq_sequencer_tb.sv
module stseq_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] regAddr = 4'h0;
   logic [31:0] regWdata = 32'h0;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [7:0] ttlTrig = 8'h0;
   wire [31:0] regRdata;
   wire [7:0] relayChan;
   wire relayClosed, busy, rangeErr, overlap;
   int closeCnt;
   int n_errors = 0;
   int tests_run = 0;
   int cyc = 0;
   logic [31:0] rv;
   always #10 clk = ~clk;
   stseq_sequencer #(.TICK_CYC(4)) i_stseq_sequencer (.clk, .rst, .regAddr, .regWdata,
      .regWr, .regRd, .regRdata, .ttlTrig, .relayChan, .relayClosed, .busy, .rangeErr);
   stseq_relay_model i_stseq_relay_model (.clk, .relayChan, .relayClosed, .closeCnt,
      .overlap);
   task chk(string n, logic [31:0] e, logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         $display("MISMATCH %s exp %h got %h", n, e, g);
         n_errors++;
      end
   endtask
   task wr(logic [3:0] a, logic [31:0] d);
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   task rd(logic [3:0] a);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      @(negedge clk);
      rv = regRdata;
   endtask
   task wait_idle;
      @(negedge clk);
      repeat (300) if (busy === 1'b1) @(negedge clk);
      chk("busy", 0, busy);
   endtask
   task run(logic [31:0] len, logic [31:0] src);
      wr(4'h5, len);
      wr(4'h3, src);
      wr(4'h0, 32'h1);
   endtask
   task t_passes;
      int c;
      c = closeCnt;
      run(32'h2, 32'h0);
      wait_idle();
      chk("closes dflt", 2, closeCnt - c);
      wr(4'h1, 32'h3);
      c = closeCnt;
      run(32'h4, 32'h0);
      wait_idle();
      chk("closes", 12, closeCnt - c);
      wr(4'h1, 32'h1);
      $display("passes done");
   endtask
   task t_range;
      wr(4'h1, 32'h0);
      rd(4'h4);
      chk("err zero", 1, rv[1]);
      wr(4'h4, 32'h2);
      wr(4'h1, 32'h10000);
      rd(4'h4);
      chk("err big", 1, rv[1]);
      wr(4'h4, 32'h2);
      wr(4'h1, 32'hffff);
      wr(4'h2, 32'hffff);
      rd(4'h4);
      chk("err max", 0, rv[1]);
      wr(4'h2, 32'h10000);
      rd(4'h4);
      chk("err dly", 1, rv[1]);
      wr(4'h4, 32'h2);
      wr(4'h1, 32'h1);
      rd(4'h9);
      chk("unmapped", 0, rv);
      $display("range done");
   endtask
   task t_hold;
      wr(4'h2, 32'h0);
      run(32'h2, 32'h1);
      ttlTrig <= 8'hff;
      wr(4'h0, 32'h8);
      ttlTrig <= 8'h0;
      repeat (20) @(negedge clk);
      chk("hold chan", 0, relayChan);
      wr(4'h0, 32'h2);
      repeat (3) @(negedge clk);
      chk("step chan", 1, relayChan);
      rd(4'h6);
      chk("chan reg", 1, rv);
      wr(4'h0, 32'h2);
      wait_idle();
      $display("hold done");
   endtask
   task t_bus;
      wr(4'h2, 32'h0);
      run(32'h2, 32'h2);
      repeat (10) @(negedge clk);
      chk("bus wait", 0, relayChan);
      wr(4'h0, 32'h8);
      repeat (3) @(negedge clk);
      chk("bus chan", 1, relayChan);
      wr(4'h0, 32'h8);
      wait_idle();
      run(32'h2, 32'h2);
      wr(4'h0, 32'h4);
      @(negedge clk);
      chk("abort busy", 0, busy);
      chk("abort open", 0, relayClosed);
      $display("bus done");
   endtask
   task t_ttl;
      wr(4'h2, 32'h3);
      for (int n = 0; n < 8; n++) begin
         run(32'h2, {27'h0, n[2:0], 2'h3});
         ttlTrig <= 8'h1 << ((n + 1) % 8);
         repeat (2) @(posedge clk);
         ttlTrig <= 8'h1 << n;
         repeat (8) @(negedge clk);
         chk("dly chan", 0, relayChan);
         @(posedge clk);
         ttlTrig <= 8'h0;
         repeat (40) if (relayChan !== 8'h1) @(negedge clk);
         chk("trig chan", 1, relayChan);
         wr(4'h0, 32'h2);
         wait_idle();
      end
      $display("ttl done");
   endtask
   task end_sim;
      $display("checks %0d errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         end_sim();
      end
   end
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      t_passes();
      t_range();
      t_hold();
      t_bus();
      t_ttl();
      chk("overlap", 0, overlap);
      end_sim();
   end
endmodule
